// ### pkg/wsns_map.vh
// Constants for the wiper stepping and nonvolatile store block
`ifndef WSNS_MAP_VH
`define WSNS_MAP_VH

// ----------------------------------------------------------------------
// Position
// ----------------------------------------------------------------------
`define WSNS_POS_W        6
`define WSNS_POS_MAX      6'h3F
`define WSNS_POS_MIN      6'h00
`define WSNS_POS_RST      6'h00
`define WSNS_STORE_BIT    3

// ----------------------------------------------------------------------
// Input sources
// ----------------------------------------------------------------------
`define WSNS_SRC_UP       2'h0
`define WSNS_SRC_DOWN     2'h1
`define WSNS_SRC_DIG      2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WSNS_CLK_MHZ      250
`define WSNS_T_DIG_US     1
`define WSNS_T_CONTACT_MS 1
`define WSNS_T_HOLD_MS    1000
`define WSNS_T_REP_MS     100
`define WSNS_T_IDLE_MS    1000
`define WSNS_T_SETTLE_MS  2000
`define WSNS_DIG_CYC      (`WSNS_T_DIG_US * `WSNS_CLK_MHZ)
`define WSNS_CONTACT_CYC  (`WSNS_T_CONTACT_MS * 1000 * `WSNS_CLK_MHZ)
`define WSNS_HOLD_CYC     (`WSNS_T_HOLD_MS * 1000 * `WSNS_CLK_MHZ)
`define WSNS_REP_CYC      (`WSNS_T_REP_MS * 1000 * `WSNS_CLK_MHZ)
`define WSNS_IDLE_CYC     (`WSNS_T_IDLE_MS * 1000 * `WSNS_CLK_MHZ)
`define WSNS_SETTLE_CYC   (`WSNS_T_SETTLE_MS * 1000 * `WSNS_CLK_MHZ)

`endif

// ### verif/wiper_step_and_nv_store_test.sv
// Self-checking bench for the wiper step and store block
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end

module wiper_step_and_nv_store_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SETTLE = 80;
  localparam int WEAR   = 1;
  logic       clock_i, sys_rst_i, down_float_i, first, arm, clk_en;
  logic [2:0] btn_n;
  logic [5:0] exp_pos, exp_nv, last_pos;
  wire  [5:0] pos, nv_rd, nv_wd;
  wire        dual, ready, nv_wr, dir;
  int         n_wr, n_mismatch, tests_run, seed, w, exp_wr, cyc_n;
  int         t_q[$];

  wsns_top #(.DIG_CYC(2), .CONTACT_CYC(4), .HOLD_CYC(40), .REP_CYC(8),
    .IDLE_CYC(40), .SETTLE_CYC(SETTLE)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
    .up_contact_in_n_i(btn_n[0]), .down_contact_in_n_i(btn_n[1]),
    .digital_in_n_i(btn_n[2]), .down_float_i(down_float_i),
    .nv_rdata_i(nv_rd), .wiper_pos_o(pos), .dir_up_o(dir),
    .dual_mode_o(dual), .ready_o(ready), .nv_write_o(nv_wr),
    .nv_wdata_o(nv_wd));
  wsns_cells #(.WEAR(WEAR)) cells (.clock_i(clock_i), .nv_write_i(nv_wr),
    .nv_wdata_i(nv_wd), .nv_rdata_o(nv_rd), .n_wr_o(n_wr));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Step times, sampled mid-cycle to stay clear of the edge
  always @(negedge clock_i) begin
    cyc_n++;
    if (pos !== last_pos) t_q.push_back(cyc_n);
    last_pos = pos;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic pulse(input int s, input int lo, input int hi);
    btn_n[s] = 1'b0;
    cyc(lo);
    btn_n[s] = 1'b1;
    cyc(hi);
  endtask
  task automatic mv(input logic up);
    logic [5:0] nx;
    nx = up ? exp_pos + 6'h01 : exp_pos - 6'h01;
    arm = arm | first | (nx[3] != exp_pos[3]);
    first = 1'b0;
    exp_pos = nx;
  endtask
  // Position held past the settle time
  task automatic settle();
    cyc(SETTLE + 10);
    if (arm) begin
      exp_wr++;
      if (exp_wr <= WEAR) exp_nv = exp_pos;
      arm = 1'b0;
    end
    `CHK("writes", exp_wr, n_wr)
    `CHK("cells", exp_nv, nv_rd)
  endtask
  task automatic do_reset(input logic fl);
    sys_rst_i = 1'b1;
    down_float_i = fl;
    cyc(8);
    sys_rst_i = 1'b0;
    cyc(2);
    exp_pos = exp_nv;
    first = 1'b1;
    arm = 1'b0;
    `CHK("load", exp_nv, pos)
    `CHK("mode", fl, dual)
    `CHK("ready", 1'b1, ready)
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock_i);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    btn_n = 3'h7;
    clk_en = 1'b1;
    sys_rst_i = 1'b1;
    down_float_i = 1'b0;
    seed = 59389;
    exp_nv = 6'h05;
    exp_wr = 0;
    cyc(1);
    do_reset(1'b0);
    pulse(0, 6, 6);
    mv(1'b1);
    `CHK("first press", exp_pos, pos)
    `CHK("dir first", 1'b1, dir)
    pulse(0, 2, 6);
    `CHK("short press", exp_pos, pos)
    repeat (6) begin
      w = ($random(seed) & 1) ? 1 : 4;
      pulse(2, w, 4);
      if (w >= 2) mv(1'b1);
    end
    `CHK("pulse run", exp_pos, pos)
    settle();
    pulse(0, 6, 6);
    mv(1'b0);
    `CHK("reverse", exp_pos, pos)
    `CHK("dir reverse", 1'b0, dir)
    settle();
    t_q.delete();
    pulse(0, 71, 6);
    repeat (5) mv(1'b1);
    `CHK("held", exp_pos, pos)
    `CHK("dir held", 1'b1, dir)
    `CHK("hold gap", 32'h28, t_q[1] - t_q[0])
    `CHK("repeat gap", 32'h8, t_q[2] - t_q[1])
    settle();
    do_reset(1'b1);
    pulse(1, 60 + 8 * exp_pos, 6);
    repeat (exp_pos) mv(1'b0);
    `CHK("low end", 6'h00, pos)
    pulse(1, 6, 6);
    `CHK("stay low", 6'h00, pos)
    pulse(0, 6, 6);
    mv(1'b1);
    `CHK("opposite", exp_pos, pos)
    // A press while the enable is low must leave no trace
    clk_en = 1'b0;
    pulse(0, 10, 10);
    clk_en = 1'b1;
    cyc(2);
    `CHK("frozen", exp_pos, pos)
    settle();
    report_and_stop();
  end
endmodule

// ### verif/wsns_cells.sv
// Nonvolatile cell array behind the store logic
module wsns_cells #(
  parameter [5:0] INIT = 6'h05,
  parameter int   WEAR = 1
) (
  input  wire        clock_i,
  input  wire        nv_write_i,
  input  wire  [5:0] nv_wdata_i,
  output logic [5:0] nv_rdata_o,
  output int         n_wr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    nv_rdata_o = INIT;
    n_wr_o = 0;
  end
  // Worn cells ignore writes
  // Wear limit is tiny so a worn array shows in a short run
  always @(posedge clock_i) begin
    if (nv_write_i === 1'b1) begin
      n_wr_o <= n_wr_o + 32'h1;
      if (n_wr_o < WEAR) nv_rdata_o <= nv_wdata_i;
    end
  end
endmodule

// ### verif/wsns_props_properties.sv
// Port-level checks of the wiper step and store block
module wsns_props #(
  parameter [31:0] SETTLE_CYC = 80
) (
  input wire       clock_i,
  input wire       sys_rst_i,
  input wire       clk_en_i,
  input wire       up_contact_in_n_i,
  input wire       down_contact_in_n_i,
  input wire       digital_in_n_i,
  input wire       down_float_i,
  input wire [5:0] nv_rdata_i,
  input wire [5:0] wiper_pos_o,
  input wire       dir_up_o,
  input wire       dual_mode_o,
  input wire       ready_o,
  input wire       nv_write_o,
  input wire [5:0] nv_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0]  pos_reg;
  logic        rdy_reg, first_reg, arm_reg;
  logic [31:0] still_reg, quiet_reg;
  wire         chg  = rdy_reg && (wiper_pos_o != pos_reg);
  wire         flip = wiper_pos_o[3] != pos_reg[3];
  wire         idle = up_contact_in_n_i && down_contact_in_n_i &&
                      digital_in_n_i;

  // The settle helper counter follows the design's notion of time; the quiet count runs on every clock
  always @(posedge clock_i) begin
    pos_reg <= wiper_pos_o;
    rdy_reg <= ready_o;
    if (sys_rst_i) begin
      still_reg <= 32'h0;
      quiet_reg <= 32'h0;
      first_reg <= 1'b1;
      arm_reg   <= 1'b0;
    end else begin
      // Settle count pauses with the enable, as the design's does
      if (chg) begin
        still_reg <= 32'h0;
      end else if (clk_en_i) begin
        still_reg <= still_reg + 32'h1;
      end
      quiet_reg <= idle ? quiet_reg + 32'h1 : 32'h0;
      first_reg <= first_reg && !chg;
      arm_reg   <= !nv_write_o && (arm_reg || (chg && (first_reg || flip)));
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_load; $rose(ready_o) |-> wiper_pos_o == $past(nv_rdata_i);
  endproperty a_load: assert property (p_load)
    else $error("bad load");
  property p_mode; $rose(ready_o) |-> dual_mode_o == $past(down_float_i);
  endproperty a_mode: assert property (p_mode)
    else $error("bad mode");
  property p_step; chg |-> 7'(wiper_pos_o) + 7'h1 == 7'(pos_reg) ||
    7'(pos_reg) + 7'h1 == 7'(wiper_pos_o);
  endproperty a_step: assert property (p_step)
    else $error("bad step");
  property p_quiet; chg |-> quiet_reg <= 32'h4;
  endproperty a_quiet: assert property (p_quiet)
    else $error("no press");
  property p_wdata; nv_write_o |-> nv_wdata_o == wiper_pos_o;
  endproperty a_wdata: assert property (p_wdata)
    else $error("wdata");
  property p_settle; nv_write_o |-> still_reg >= SETTLE_CYC - 32'h3 &&
    still_reg <= SETTLE_CYC + 32'h2;
  endproperty a_settle: assert property (p_settle)
    else $error("early");
  property p_armed; nv_write_o |-> arm_reg;
  endproperty a_armed: assert property (p_armed)
    else $error("unarmed");
  property p_once; nv_write_o |=> !nv_write_o [*8];
  endproperty a_once: assert property (p_once)
    else $error("double");
endmodule

bind wsns_top wsns_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .up_contact_in_n_i(up_contact_in_n_i),
  .down_contact_in_n_i(down_contact_in_n_i),
  .digital_in_n_i(digital_in_n_i), .down_float_i(down_float_i),
  .nv_rdata_i(nv_rdata_i), .wiper_pos_o(wiper_pos_o),
  .dir_up_o(dir_up_o), .dual_mode_o(dual_mode_o), .ready_o(ready_o),
  .nv_write_o(nv_write_o), .nv_wdata_o(nv_wdata_o));

// ### verilog/wsns_top.v
// Wiper step interpreter with nonvolatile store policy
`include "wsns_map.vh"

module wsns_top #(
  parameter [31:0] DIG_CYC     = `WSNS_DIG_CYC,
  parameter [31:0] CONTACT_CYC = `WSNS_CONTACT_CYC,
  parameter [31:0] HOLD_CYC    = `WSNS_HOLD_CYC,
  parameter [31:0] REP_CYC     = `WSNS_REP_CYC,
  parameter [31:0] IDLE_CYC    = `WSNS_IDLE_CYC,
  parameter [31:0] SETTLE_CYC  = `WSNS_SETTLE_CYC
) (
  input  wire                   clock_i,
  input  wire                   sys_rst_i,
  input  wire                   clk_en_i,
  input  wire                   up_contact_in_n_i,
  input  wire                   down_contact_in_n_i,
  input  wire                   digital_in_n_i,
  input  wire                   down_float_i,
  input  wire [`WSNS_POS_W-1:0] nv_rdata_i,
  output reg  [`WSNS_POS_W-1:0] wiper_pos_o,
  output reg                    dir_up_o,
  output reg                    dual_mode_o,
  output reg                    ready_o,
  output reg                    nv_write_o,
  output reg  [`WSNS_POS_W-1:0] nv_wdata_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Saturating step
  function [`WSNS_POS_W-1:0] wsns_step;
    input [`WSNS_POS_W-1:0] pos;
    input                   up;
    begin
      if (up) begin
        wsns_step = (pos == `WSNS_POS_MAX) ? pos : pos + 6'h01;
      end else begin
        wsns_step = (pos == `WSNS_POS_MIN) ? pos : pos - 6'h01;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------------
  wire [2:0]  raw_n;
  reg  [2:0]  stable_reg;
  reg  [2:0]  stable_d_reg;
  reg  [31:0] qual_cnt_reg [0:2];
  wire [2:0]  fall;

  assign raw_n = {digital_in_n_i, down_contact_in_n_i, up_contact_in_n_i};

  // Digital input qualifies fast, contacts slow enough to debounce
  function [31:0] wsns_min_cyc;
    input integer idx;
    begin
      wsns_min_cyc = (idx == 2) ? DIG_CYC : CONTACT_CYC;
    end
  endfunction

  // One process owns all three filters, so each vector has one driver
  integer     qi;
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      stable_reg <= 3'h7;
      for (qi = 0; qi < 3; qi = qi + 1) begin
        qual_cnt_reg[qi] <= 32'h0000_0000;
      end
    end else if (clk_en_i) begin
      for (qi = 0; qi < 3; qi = qi + 1) begin
        if (raw_n[qi] == stable_reg[qi]) begin
          qual_cnt_reg[qi] <= 32'h0000_0000;
        end else if (qual_cnt_reg[qi] >= wsns_min_cyc(qi) - 32'h1) begin
          stable_reg[qi]   <= raw_n[qi];
          qual_cnt_reg[qi] <= 32'h0000_0000;
        end else begin
          qual_cnt_reg[qi] <= qual_cnt_reg[qi] + 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg                   init_reg;
  reg                   dual_reg;
  reg [`WSNS_POS_W-1:0] pos_reg;
  reg                   dir_reg;
  reg [1:0]             src_reg;
  reg [31:0]            hold_reg;
  reg                   rep_reg;
  reg [31:0]            idle_reg;
  reg                   idle_long_reg;
  reg                   first_done_reg;
  reg                   pending_reg;
  reg [31:0]            settle_reg;

  // Press starts on a falling edge; down contact unused in single mode
  assign fall = stable_d_reg & ~stable_reg & {1'b1, dual_reg, 1'b1} &
                {3{~init_reg}};

  // ----------------------------------------------------------------------
  // Step decision
  // ----------------------------------------------------------------------
  reg                   step_go;
  reg [1:0]             src_next;
  reg                   single_src;
  reg                   dir_use;
  reg                   step_up;
  reg [`WSNS_POS_W-1:0] pos_next;
  reg                   single_act;

  always @* begin
    step_go  = 1'b0;
    src_next = src_reg;
    if (fall[0]) begin
      src_next = `WSNS_SRC_UP;
    end else if (fall[1]) begin
      src_next = `WSNS_SRC_DOWN;
    end else if (fall[2]) begin
      src_next = `WSNS_SRC_DIG;
    end
    if (|fall) begin
      step_go = 1'b1;
    end else if (!init_reg && !stable_reg[src_reg]) begin
      if (!rep_reg && hold_reg >= HOLD_CYC - 32'h1) begin
        step_go = 1'b1;
      end else if (rep_reg && hold_reg >= REP_CYC - 32'h1) begin
        step_go = 1'b1;
      end
    end
    single_src = (src_next == `WSNS_SRC_DIG) || !dual_reg;
    // Reverse only when a new press follows a long idle
    dir_use = (|fall && idle_long_reg) ? ~dir_reg : dir_reg;
    if (single_src) begin
      step_up = dir_use;
    end else begin
      // Dual mode: each contact owns its direction
      step_up = (src_next == `WSNS_SRC_UP);
    end
    pos_next   = step_go ? wsns_step(pos_reg, step_up) : pos_reg;
    single_act = !stable_reg[2] || (!stable_reg[0] && !dual_reg);
  end

  // ----------------------------------------------------------------------
  // Sequential update
  // ----------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      init_reg       <= 1'b1;
      dual_reg       <= 1'b0;
      pos_reg        <= `WSNS_POS_RST;
      dir_reg        <= 1'b0;
      src_reg        <= `WSNS_SRC_UP;
      hold_reg       <= 32'h0000_0000;
      rep_reg        <= 1'b0;
      idle_reg       <= 32'h0000_0000;
      idle_long_reg  <= 1'b1;
      first_done_reg <= 1'b0;
      pending_reg    <= 1'b0;
      settle_reg     <= 32'h0000_0000;
      stable_d_reg   <= 3'h7;
      nv_write_o     <= 1'b0;
      nv_wdata_o     <= `WSNS_POS_RST;
      wiper_pos_o    <= `WSNS_POS_RST;
      dir_up_o       <= 1'b0;
      dual_mode_o    <= 1'b0;
      ready_o        <= 1'b0;
    end else if (clk_en_i) begin
      stable_d_reg <= stable_reg;
      nv_write_o   <= 1'b0;
      if (init_reg) begin
        // Restore from the cells, catch the mode strap
        init_reg <= 1'b0;
        pos_reg  <= nv_rdata_i;
        // Floating down contact selects dual mode
        dual_reg <= down_float_i;
      end else begin
        src_reg <= src_next;
        pos_reg <= pos_next;
        // Hold timer restarts on every press and every repeat step
        if (|fall) begin
          hold_reg <= 32'h0000_0000;
          rep_reg  <= 1'b0;
        end else if (!stable_reg[src_reg]) begin
          if (step_go) begin
            hold_reg <= 32'h0000_0000;
            rep_reg  <= 1'b1;
          end else begin
            hold_reg <= hold_reg + 32'h1;
          end
        end
        if (single_act) begin
          idle_reg      <= 32'h0000_0000;
          idle_long_reg <= 1'b0;
        end else if (idle_reg >= IDLE_CYC - 32'h1) begin
          idle_long_reg <= 1'b1;
        end else begin
          idle_reg <= idle_reg + 32'h1;
        end
        // Single-type steps also reverse at either end
        if (step_go && single_src) begin
          if (pos_next == `WSNS_POS_MAX) begin
            dir_reg <= 1'b0;
          end else if (pos_next == `WSNS_POS_MIN) begin
            dir_reg <= 1'b1;
          end else begin
            dir_reg <= step_up;
          end
        end
        // Store policy, driven from the live position alone
        if (pos_next != pos_reg) begin
          // Any change restarts the settle delay
          settle_reg <= 32'h0000_0000;
          // First change, or a bit 3 flip, arms a store
          if (!first_done_reg ||
              (pos_next[`WSNS_STORE_BIT] != pos_reg[`WSNS_STORE_BIT])) begin
            pending_reg <= 1'b1;
          end
        end else if (pending_reg) begin
          if (settle_reg >= SETTLE_CYC - 32'h1) begin
            // Internal write of the settled position
            pending_reg    <= 1'b0;
            first_done_reg <= 1'b1;
            settle_reg     <= 32'h0000_0000;
            nv_write_o     <= 1'b1;
            nv_wdata_o     <= pos_reg;
          end else begin
            settle_reg <= settle_reg + 32'h1;
          end
        end
      end
      wiper_pos_o <= init_reg ? nv_rdata_i : pos_next;
      dir_up_o    <= dir_reg;
      dual_mode_o <= init_reg ? down_float_i : dual_reg;
      ready_o     <= 1'b1;
    end
  end

endmodule
